// File: logic/clp_pkg.sv
// Shared constants for the bus-linked I/O node register port.
package clp_pkg;
	// Register addresses carried in the first data byte.
	localparam logic [7:0] ADDR_INPUT_LEVELS = 8'h00;
	localparam logic [7:0] ADDR_RISE_CAPTURE = 8'h01;
	localparam logic [7:0] ADDR_FALL_CAPTURE = 8'h02;
	localparam logic [7:0] ADDR_OUTPUT_LEVELS = 8'h03;
	localparam logic [7:0] ADDR_DRIVER_ENABLE = 8'h04;
	localparam logic [7:0] ADDR_ANALOG_SETUP = 8'h05;
	localparam logic [7:0] ADDR_PULSE_ONE = 8'h06;
	localparam logic [7:0] ADDR_PULSE_TWO = 8'h07;
	localparam logic [7:0] ADDR_CONVERSION = 8'h08;
	// Reset values.
	localparam logic [15:0] RESET_WORD = 16'h0000;
	// Analog setup field positions.
	localparam int AS_START = 15;
	localparam int AS_CMP_LSB = 12;
	localparam int AS_ROUTE_LSB = 8;
	localparam int AS_SW_LSB = 5;
	localparam logic [15:0] AS_WRITE_MASK = 16'h87e0;
	// Ten-bit fields sit in bits 15:6.
	localparam int TEN_LSB = 6;
	// Pin roles.
	localparam int PIN_CMP1 = 7;
	localparam int PIN_CMP2 = 9;
	localparam int PIN_CMP3 = 8;
	localparam int PIN_PULSE_ONE = 10;
	localparam int PIN_PULSE_TWO = 4;
	// Pulse slot length in clocks and converter window length.
	localparam int PULSE_CLKS = 4;
	localparam int CONV_WINDOW = 1024;
	// Bit rate limits.
	localparam int CLK_HZ = 200_000_000;
	localparam int RATE_MIN_KBPS = 20;
	localparam int RATE_MAX_KBPS = 125;
	localparam int BIT_CLKS_MAX = CLK_HZ / (RATE_MIN_KBPS * 1000);
	localparam int BIT_CLKS_MIN = (CLK_HZ + RATE_MAX_KBPS * 1000 - 1) / (RATE_MAX_KBPS * 1000);
	// Transmit message kinds.
	typedef enum logic [3:0] {
		CLP_TX_IDLE = 4'b0001,
		CLP_TX_RESP = 4'b0010,
		CLP_TX_CONV = 4'b0100,
		CLP_TX_INPUT = 4'b1000
	} clp_tx_t;
endpackage

// File: logic/clp_register_port.sv
// Register bank, port control and message scheduling of the remote I/O node.

////////////////////////////////////////////////////////////////////////////////
// Pulse-density generator: N pulses of four clocks spread over 1024 slots.
module clp_pulse_gen (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Control
	input wire logic [9:0] count,
	input wire logic invert,
	// Output
	output logic pulse
);
	logic [1:0] slot_ff;
	logic [9:0] acc_ff;
	logic hit_ff;
	logic [10:0] sum;

	assign sum = {1'b0, acc_ff} + {1'b0, count};

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			slot_ff <= 2'h0;
			acc_ff <= 10'h000;
			hit_ff <= 1'b0;
		end else begin
			slot_ff <= slot_ff + 2'h1;
			if (slot_ff == 2'(clp_pkg::PULSE_CLKS - 1)) begin
				acc_ff <= sum[9:0];
				hit_ff <= sum[10];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pulse <= 1'b0;
		end else begin
			pulse <= hit_ff ^ invert;
		end
	end
endmodule // clp_pulse_gen

////////////////////////////////////////////////////////////////////////////////
module clp_register_port (
	// Clock and resets
	input wire logic clk,
	input wire logic reset_n,
	input wire logic reset_pin,
	input wire logic osc_select_pin,
	// Frames decoded by the protocol engine
	input wire logic rx_frame_valid,
	input wire logic rx_frame_remote,
	input wire logic [7:0] rx_byte1,
	input wire logic [7:0] rx_byte2,
	input wire logic [7:0] rx_byte3,
	// Frames handed to the protocol engine
	output logic tx_req,
	output logic [3:0] tx_status,
	output logic [7:0] tx_addr,
	output logic [15:0] tx_data,
	input wire logic tx_done,
	// Bus pins and engine bit stream
	input wire logic bus_in_a,
	input wire logic bus_in_b,
	input wire logic bus_mode2,
	input wire logic tx_bit,
	output logic rx_bit,
	output logic bus_out_low_drive_o,
	output logic bus_out_low_drive_oe,
	output logic bus_out_high_drive_o,
	output logic bus_out_high_drive_oe,
	output logic [15:0] bit_time,
	// Sleep control
	input wire logic sleep_req,
	output logic asleep,
	// Port pins
	input wire logic [15:0] port_in,
	output logic [15:0] port_out,
	output logic [15:0] port_oe,
	// Analog side
	input wire logic [2:0] comparator_result_bit,
	output logic [2:0] analog_switch_select,
	output logic converter_feedback_out,
	// Node identity and mode
	output logic [3:0] node_id_bits,
	output logic ext_clock_mode
);
	logic sync1_ff;
	logic rst_n;
	logic arst_n;
	logic [15:0] rise_ff;
	logic [15:0] fall_ff;
	logic [15:0] out_ff;
	logic [15:0] oe_ff;
	logic [15:0] analog_ff;
	logic [9:0] pulse_one_ff;
	logic [9:0] pulse_two_ff;
	logic [9:0] result_ff;
	logic [15:0] prev_in_ff;
	logic id_done_ff;
	logic input_pend_ff;
	logic resp_pend_ff;
	logic conv_pend_ff;
	logic [7:0] resp_addr_ff;
	logic conv_busy_ff;
	logic [9:0] conv_cnt_ff;
	logic [9:0] conv_acc_ff;
	logic conv_done;
	logic conv_start;
	logic wr;
	logic [15:0] wr_word;
	logic edge_hit;
	logic wake;
	logic pulse_one;
	logic pulse_two;
	logic [15:0] rx_run_ff;
	logic rx_prev_ff;
	clp_pkg::clp_tx_t tx_state_ff;
	clp_pkg::clp_tx_t nxt_tx_state;

	////////////////////////////////////////////////////////////////////////////
	// Reset: internal mode is reset-pin high with mode pin grounded, external
	// mode holds the reset pin high and uses a low mode pin as reset.
	assign arst_n = reset_n & ~(reset_pin & ~osc_select_pin);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sync1_ff <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			sync1_ff <= 1'b1;
			rst_n <= sync1_ff;
		end
	end

	// Identifier straps and mode are caught on the first edge after release.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			id_done_ff <= 1'b0;
			node_id_bits <= 4'h0;
			ext_clock_mode <= 1'b0;
		end else if (!id_done_ff) begin
			id_done_ff <= 1'b1;
			node_id_bits <= port_in[3:0];
			ext_clock_mode <= osc_select_pin;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register writes.
	assign wr = rx_frame_valid & ~rx_frame_remote;
	assign wr_word = {rx_byte2, rx_byte3};

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rise_ff <= clp_pkg::RESET_WORD;
			fall_ff <= clp_pkg::RESET_WORD;
			out_ff <= clp_pkg::RESET_WORD;
			oe_ff <= clp_pkg::RESET_WORD;
			pulse_one_ff <= 10'h000;
			pulse_two_ff <= 10'h000;
		end else if (wr) begin
			// Input level and conversion result take no write.
			unique case (rx_byte1)
				clp_pkg::ADDR_RISE_CAPTURE: rise_ff <= wr_word;
				clp_pkg::ADDR_FALL_CAPTURE: fall_ff <= wr_word;
				clp_pkg::ADDR_OUTPUT_LEVELS: out_ff <= wr_word;
				clp_pkg::ADDR_DRIVER_ENABLE: oe_ff <= wr_word;
				clp_pkg::ADDR_PULSE_ONE: pulse_one_ff <= wr_word[15:clp_pkg::TEN_LSB];
				clp_pkg::ADDR_PULSE_TWO: pulse_two_ff <= wr_word[15:clp_pkg::TEN_LSB];
				default: ;
			endcase
		end
	end

	// Analog setup: start, route and switch bits are written; comparator bits
	// are live and the start bit clears itself when the result is ready.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			analog_ff <= clp_pkg::RESET_WORD;
		end else if (wr && rx_byte1 == clp_pkg::ADDR_ANALOG_SETUP) begin
			analog_ff <= wr_word & clp_pkg::AS_WRITE_MASK;
		end else if (conv_done) begin
			analog_ff[clp_pkg::AS_START] <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Converter: delta-sigma over a 1024-clock window, feedback opposes pin 15.
	assign conv_start = wr && (rx_byte1 == clp_pkg::ADDR_CONVERSION ||
		(rx_byte1 == clp_pkg::ADDR_ANALOG_SETUP && rx_byte2[7]));
	assign conv_done = conv_busy_ff && conv_cnt_ff == 10'(clp_pkg::CONV_WINDOW - 1);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			conv_busy_ff <= 1'b0;
			conv_cnt_ff <= 10'h000;
			conv_acc_ff <= 10'h000;
			result_ff <= 10'h000;
			converter_feedback_out <= 1'b0;
		end else begin
			converter_feedback_out <= conv_busy_ff & ~port_in[15];
			if (conv_done) begin
				result_ff <= conv_acc_ff;
			end
			// A start on the last window clock opens a fresh window, or the start
			// bit it leaves set would never be cleared.
			if (conv_start && (!conv_busy_ff || conv_done)) begin
				conv_busy_ff <= 1'b1;
				conv_cnt_ff <= 10'h000;
				conv_acc_ff <= 10'h000;
			end else if (conv_busy_ff) begin
				conv_cnt_ff <= conv_cnt_ff + 10'h001;
				conv_acc_ff <= conv_acc_ff + {9'h000, ~port_in[15]};
				if (conv_done) begin
					conv_busy_ff <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			analog_switch_select <= 3'h0;
		end else begin
			analog_switch_select <= analog_ff[clp_pkg::AS_SW_LSB +: 3];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Port pins.
	clp_pulse_gen u_pulse_one (
		.clk(clk),
		.rst_n(rst_n),
		.count(pulse_one_ff),
		.invert(out_ff[clp_pkg::PIN_PULSE_ONE]),
		.pulse(pulse_one)
	);

	clp_pulse_gen u_pulse_two (
		.clk(clk),
		.rst_n(rst_n),
		.count(pulse_two_ff),
		.invert(out_ff[clp_pkg::PIN_PULSE_TWO]),
		.pulse(pulse_two)
	);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			port_out <= 16'h0000;
			port_oe <= 16'h0000;
		end else begin
			port_out <= out_ff;
			port_oe <= oe_ff;
			// Pin zero is the clock input in external mode and is never driven.
			if (ext_clock_mode) begin
				port_oe[0] <= 1'b0;
			end
			if (analog_ff[clp_pkg::AS_ROUTE_LSB]) begin
				port_out[clp_pkg::PIN_CMP1] <= comparator_result_bit[0];
			end
			if (analog_ff[clp_pkg::AS_ROUTE_LSB + 1]) begin
				port_out[clp_pkg::PIN_CMP2] <= comparator_result_bit[1];
			end
			if (analog_ff[clp_pkg::AS_ROUTE_LSB + 2]) begin
				port_out[clp_pkg::PIN_CMP3] <= comparator_result_bit[2];
			end
			// A zero count keeps the plain port function on that pin.
			if (pulse_one_ff != 10'h000) begin
				port_out[clp_pkg::PIN_PULSE_ONE] <= pulse_one;
			end
			if (pulse_two_ff != 10'h000) begin
				port_out[clp_pkg::PIN_PULSE_TWO] <= pulse_two;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Bus pins, bit rate measurement and sleep.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_bit <= 1'b1;
			bus_out_low_drive_o <= 1'b0;
			bus_out_low_drive_oe <= 1'b0;
			bus_out_high_drive_o <= 1'b1;
			bus_out_high_drive_oe <= 1'b0;
		end else begin
			// Dominant when input a sits below input b.
			rx_bit <= bus_in_a | ~bus_in_b;
			bus_out_low_drive_oe <= ~tx_bit & ~asleep;
			bus_out_high_drive_oe <= ~tx_bit & ~asleep & ~bus_mode2;
		end
	end

	// Shortest dominant run within the legal range is taken as one bit time.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_prev_ff <= 1'b1;
			rx_run_ff <= 16'h0000;
			bit_time <= 16'(clp_pkg::BIT_CLKS_MAX);
		end else begin
			rx_prev_ff <= rx_bit;
			if (!rx_bit && rx_run_ff != 16'hffff) begin
				rx_run_ff <= rx_run_ff + 16'h0001;
			end else if (rx_bit) begin
				rx_run_ff <= 16'h0000;
			end
			if (rx_bit && !rx_prev_ff && rx_run_ff >= 16'(clp_pkg::BIT_CLKS_MIN) &&
				rx_run_ff <= 16'(clp_pkg::BIT_CLKS_MAX) && rx_run_ff < bit_time) begin
				bit_time <= rx_run_ff;
			end
		end
	end

	assign wake = asleep & ~rx_bit;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			asleep <= 1'b0;
		end else if (wake) begin
			asleep <= 1'b0;
		end else if (sleep_req && tx_state_ff == clp_pkg::CLP_TX_IDLE) begin
			asleep <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Message scheduling. Pending flags: a new cause wins over the clear.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_in_ff <= 16'h0000;
		end else begin
			prev_in_ff <= port_in;
		end
	end

	assign edge_hit = id_done_ff && |((port_in & ~prev_in_ff & rise_ff) |
		(~port_in & prev_in_ff & fall_ff));

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			input_pend_ff <= 1'b0;
			resp_pend_ff <= 1'b0;
			conv_pend_ff <= 1'b0;
			resp_addr_ff <= 8'h00;
		end else begin
			if (rx_frame_valid && rx_frame_remote || edge_hit || wake) begin
				input_pend_ff <= 1'b1;
			end else if (tx_done && tx_state_ff == clp_pkg::CLP_TX_INPUT) begin
				input_pend_ff <= 1'b0;
			end
			if (wr) begin
				resp_pend_ff <= 1'b1;
				resp_addr_ff <= rx_byte1;
			end else if (tx_done && tx_state_ff == clp_pkg::CLP_TX_RESP) begin
				resp_pend_ff <= 1'b0;
			end
			if (conv_done) begin
				conv_pend_ff <= 1'b1;
			end else if (tx_done && tx_state_ff == clp_pkg::CLP_TX_CONV) begin
				conv_pend_ff <= 1'b0;
			end
		end
	end

	always_comb begin
		nxt_tx_state = tx_state_ff;
		unique case (tx_state_ff)
			clp_pkg::CLP_TX_IDLE: begin
				if (asleep) begin
					nxt_tx_state = clp_pkg::CLP_TX_IDLE;
				end else if (resp_pend_ff && !wr) begin
					nxt_tx_state = clp_pkg::CLP_TX_RESP;
				end else if (conv_pend_ff) begin
					nxt_tx_state = clp_pkg::CLP_TX_CONV;
				end else if (input_pend_ff) begin
					nxt_tx_state = clp_pkg::CLP_TX_INPUT;
				end
			end
			clp_pkg::CLP_TX_RESP, clp_pkg::CLP_TX_CONV, clp_pkg::CLP_TX_INPUT: begin
				if (tx_done) begin
					nxt_tx_state = clp_pkg::CLP_TX_IDLE;
				end
			end
			default: nxt_tx_state = clp_pkg::CLP_TX_IDLE;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_state_ff <= clp_pkg::CLP_TX_IDLE;
		end else begin
			tx_state_ff <= nxt_tx_state;
		end
	end

	assign tx_req = tx_state_ff != clp_pkg::CLP_TX_IDLE;

	// Payload follows its sources until the engine takes it, so a level that
	// changes before transmission is sent as it now stands.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_addr <= 8'h00;
			tx_data <= 16'h0000;
			tx_status <= 4'h0;
		end else begin
			tx_status <= {ext_clock_mode, conv_busy_ff, bus_mode2, input_pend_ff};
			unique case (nxt_tx_state)
				clp_pkg::CLP_TX_CONV: begin
					tx_addr <= clp_pkg::ADDR_CONVERSION;
					tx_data <= {result_ff, 6'h00};
				end
				clp_pkg::CLP_TX_INPUT: begin
					tx_addr <= clp_pkg::ADDR_INPUT_LEVELS;
					tx_data <= port_in;
				end
				clp_pkg::CLP_TX_RESP: begin
					tx_addr <= resp_addr_ff;
					unique case (resp_addr_ff)
						clp_pkg::ADDR_INPUT_LEVELS: tx_data <= port_in;
						clp_pkg::ADDR_RISE_CAPTURE: tx_data <= rise_ff;
						clp_pkg::ADDR_FALL_CAPTURE: tx_data <= fall_ff;
						clp_pkg::ADDR_OUTPUT_LEVELS: tx_data <= out_ff;
						clp_pkg::ADDR_DRIVER_ENABLE: tx_data <= oe_ff;
						clp_pkg::ADDR_ANALOG_SETUP: tx_data <= analog_ff |
							{1'b0, comparator_result_bit[2:0], 12'h000};
						clp_pkg::ADDR_PULSE_ONE: tx_data <= {pulse_one_ff, 6'h00};
						clp_pkg::ADDR_PULSE_TWO: tx_data <= {pulse_two_ff, 6'h00};
						clp_pkg::ADDR_CONVERSION: tx_data <= {result_ff, 6'h00};
						default: tx_data <= 16'h0000;
					endcase
				end
				default: ;
			endcase
		end
	end
endmodule // clp_register_port

// File: test/clp_register_port_chk.sv
// Concurrent checks on the pins of the register port.
module clp_register_port_chk (
	// Clock and resets
	input wire logic clk,
	input wire logic reset_n,
	input wire logic reset_pin,
	input wire logic osc_select_pin,
	// Frames in and out
	input wire logic rx_frame_valid,
	input wire logic rx_frame_remote,
	input wire logic [7:0] rx_byte1,
	input wire logic [7:0] rx_byte2,
	input wire logic [7:0] rx_byte3,
	input wire logic tx_req,
	input wire logic [7:0] tx_addr,
	input wire logic [15:0] tx_data,
	input wire logic tx_done,
	// Bus and port pins
	input wire logic bus_mode2,
	input wire logic tx_bit,
	input wire logic bus_out_low_drive_o,
	input wire logic bus_out_low_drive_oe,
	input wire logic bus_out_high_drive_oe,
	input wire logic [15:0] port_in,
	input wire logic [15:0] port_oe
);
	logic any_reset;
	logic data_in;
	logic [15:0] word_ff;
	// The pin reset counts as well, so both reset paths silence the checks.
	assign any_reset = !reset_n || (reset_pin && !osc_select_pin);
	assign data_in = rx_frame_valid && !rx_frame_remote;
	always_ff @(posedge clk) begin
		if (rx_frame_valid) begin
			word_ff <= {rx_byte2, rx_byte3};
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (any_reset);
	sequence s_taken_idle;
		data_in && !tx_req;
	endsequence
	sequence s_answered;
		##2 tx_req && tx_addr == $past(rx_byte1, 2);
	endsequence
	AST_LOW_DRIVE: assert property (!bus_out_low_drive_o && bus_out_low_drive_oe == !$past(tx_bit))
		else $error("low drive enable wrong");
	AST_HIGH_DRIVE: assert property (bus_out_high_drive_oe == (!$past(tx_bit) && !$past(bus_mode2)))
		else $error("high drive enable wrong");
	AST_MODE2_FLOAT: assert property (bus_mode2 && $past(bus_mode2) |-> !bus_out_high_drive_oe)
		else $error("high drive not floating in mode two");
	AST_ANSWER: assert property (s_taken_idle |-> s_answered)
		else $error("no answer to data frame");
	AST_STANDS: assert property (tx_req && !tx_done && !rx_frame_valid |=> tx_req && $stable(tx_addr))
		else $error("offered frame withdrawn");
	AST_ENDS: assert property (tx_done && tx_req && !rx_frame_valid |=> !tx_req)
		else $error("frame offer not ended");
	AST_POLL: assert property (rx_frame_valid && rx_frame_remote && !tx_req |-> ##[1:4] tx_req && tx_addr == 8'h00)
		else $error("remote frame not answered");
	AST_DRIVER_EN: assert property (data_in && rx_byte1 == clp_pkg::ADDR_DRIVER_ENABLE |-> ##[2:3] port_oe == word_ff)
		else $error("driver enable not applied");
	AST_RO_DISCARD: assert property (s_taken_idle and rx_byte1 == clp_pkg::ADDR_INPUT_LEVELS |-> ##2 tx_data == $past(port_in, 1))
		else $error("read-only register altered");
endmodule // clp_register_port_chk

// File: test/clp_host_model.sv
// Host node model: sends frames to the port and acknowledges its replies.
module clp_host_model (
	// Clock
	input wire logic clk,
	// Frames towards the port
	output logic rx_frame_valid,
	output logic rx_frame_remote,
	output logic [7:0] rx_byte1,
	output logic [7:0] rx_byte2,
	output logic [7:0] rx_byte3,
	// Frames from the port
	input wire logic tx_req,
	input wire logic [7:0] tx_addr,
	input wire logic [15:0] tx_data,
	output logic tx_done
);
	timeunit 1ns;
	timeprecision 100ps;
	int ack_delay = 0;
	int got_count = 0;
	logic [7:0] got_addr;
	logic [15:0] got_data;
	initial begin
		rx_frame_valid = 1'b0;
		rx_frame_remote = 1'b0;
		{rx_byte1, rx_byte2, rx_byte3} = 24'h0;
		tx_done = 1'b0;
	end
	// Bytes are inverted once the frame is gone so stale values never pass.
	task automatic send(input logic remote, input logic [7:0] addr, input logic [15:0] value);
		@(posedge clk);
		#1;
		rx_frame_valid = 1'b1;
		rx_frame_remote = remote;
		rx_byte1 = addr;
		{rx_byte2, rx_byte3} = value;
		@(posedge clk);
		#1;
		rx_frame_valid = 1'b0;
		rx_frame_remote = ~remote;
		{rx_byte1, rx_byte2, rx_byte3} = ~{addr, value};
	endtask
	// A slow host is modelled by ack_delay cycles before taking a reply.
	always begin
		@(posedge clk);
		#1;
		if (tx_req === 1'b1) begin
			repeat (ack_delay) @(posedge clk);
			#1;
			got_addr = tx_addr;
			got_data = tx_data;
			got_count++;
			tx_done = 1'b1;
			@(posedge clk);
			#1;
			tx_done = 1'b0;
		end
	end
endmodule // clp_host_model

// File: test/clp_register_port_tb.sv
// Self-checking bench for the register port driven by a host model.
module clp_register_port_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, reset_n, reset_pin, osc_select_pin, bus_in_a, bus_in_b, bus_mode2, tx_bit, sleep_req;
	logic [15:0] port_in;
	logic [2:0] comparator_result_bit;
	logic rx_frame_valid, rx_frame_remote, tx_req, tx_done, rx_bit, asleep, converter_feedback_out;
	logic bus_out_low_drive_o, bus_out_low_drive_oe, bus_out_high_drive_o, bus_out_high_drive_oe;
	logic [7:0] rx_byte1, rx_byte2, rx_byte3, tx_addr;
	logic [15:0] tx_data, bit_time, port_out, port_oe;
	logic [3:0] tx_status, node_id_bits;
	logic [2:0] analog_switch_select;
	logic ext_clock_mode;
	int fails = 0;
	int check_count = 0;
	int seen = 0;
	clp_register_port i_dut (.clk, .reset_n, .reset_pin, .osc_select_pin, .rx_frame_valid,
		.rx_frame_remote, .rx_byte1, .rx_byte2, .rx_byte3, .tx_req, .tx_status, .tx_addr,
		.tx_data, .tx_done, .bus_in_a, .bus_in_b, .bus_mode2, .tx_bit, .rx_bit,
		.bus_out_low_drive_o, .bus_out_low_drive_oe, .bus_out_high_drive_o,
		.bus_out_high_drive_oe, .bit_time, .sleep_req, .asleep, .port_in, .port_out, .port_oe,
		.comparator_result_bit, .analog_switch_select, .converter_feedback_out, .node_id_bits,
		.ext_clock_mode);
	clp_host_model i_host (.clk, .rx_frame_valid, .rx_frame_remote, .rx_byte1, .rx_byte2,
		.rx_byte3, .tx_req, .tx_addr, .tx_data, .tx_done);
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Waits a bounded time for the next reply and compares it.
	task automatic wait_frame(input logic [7:0] a, input logic [15:0] d);
		int n;
		n = 0;
		while (i_host.got_count == seen && n < 300) begin
			@(posedge clk);
			n++;
		end
		#1;
		if (n == 300) begin
			fails++;
			$display("mismatch reply expected frame seen none");
			end_of_test();
		end else begin
			seen = i_host.got_count;
			check("reply_addr", {8'h00, a}, {8'h00, i_host.got_addr});
			check("reply_data", d, i_host.got_data);
		end
	endtask
	task automatic write(input logic [7:0] a, input logic [15:0] v, input logic [15:0] back);
		i_host.send(1'b0, a, v);
		wait_frame(a, back);
	endtask
	////////////////////////////////////////////////////////////
	task automatic t_write_back();
		logic [15:0] m;
		for (int i = 1; i < 8; i++) begin
			m = (i == 5) ? 16'h07e0 : ((i > 5) ? 16'hffc0 : 16'hffff);
			write(8'(i), 16'h5a5a, 16'h5a5a & m);
		end
		check("switch_select", 16'h0002, {13'h0, analog_switch_select});
	endtask
	task automatic t_out_enable();
		write(clp_pkg::ADDR_OUTPUT_LEVELS, 16'h9c35, 16'h9c35);
		write(clp_pkg::ADDR_DRIVER_ENABLE, 16'h000f, 16'h000f);
		step(3);
		check("pins_on", 16'h0005, {12'h0, port_out[3:0] & port_oe[3:0]});
		// Only the second comparator is routed, so pins 8 and 7 keep plain data.
		comparator_result_bit = 3'h7;
		step(3);
		check("cmp_route", 16'h0004, {13'h0, port_out[9:7]});
		comparator_result_bit = 3'h0;
		write(clp_pkg::ADDR_DRIVER_ENABLE, 16'h0000, 16'h0000);
		step(3);
		check("pins_off", 16'h0000, port_oe);
	endtask
	task automatic t_read_only();
		write(clp_pkg::ADDR_INPUT_LEVELS, 16'hffff, port_in);
		i_host.send(1'b1, 8'h00, 16'h0000);
		wait_frame(8'h00, port_in);
	endtask
	task automatic t_convert();
		write(clp_pkg::ADDR_CONVERSION, 16'h0000, 16'h0000);
		check("feedback", 16'h0001, 16'(converter_feedback_out));
		check("status_busy", 16'h0004, {12'h0, tx_status & 4'h4});
		step(1030);
		// Pin 15 stays low for the whole window, so the count ends at full scale.
		wait_frame(clp_pkg::ADDR_CONVERSION, 16'hffc0);
	endtask
	task automatic t_edge();
		write(clp_pkg::ADDR_RISE_CAPTURE, 16'h0060, 16'h0060);
		write(clp_pkg::ADDR_FALL_CAPTURE, 16'h0040, 16'h0040);
		i_host.ack_delay = 4;
		port_in[6] = 1'b1;
		wait_frame(8'h00, port_in);
		port_in[6] = 1'b0;
		wait_frame(8'h00, port_in);
		port_in[5] = 1'b0;
		step(40);
		check("no_fall_frame", 16'(seen), 16'(i_host.got_count));
		port_in[5] = 1'b1;
		wait_frame(8'h00, port_in);
		i_host.ack_delay = 0;
	endtask
	task automatic t_bus();
		for (int i = 0; i < 4; i++) begin
			tx_bit = i[0];
			bus_mode2 = i[1];
			step(3);
			check("low_oe", 16'(!i[0]), 16'(bus_out_low_drive_oe));
			check("high_oe", 16'(!i[0] && !i[1]), 16'(bus_out_high_drive_oe));
			check("levels", 16'h0002, {14'h0, bus_out_high_drive_o, bus_out_low_drive_o});
		end
		tx_bit = 1'b1;
		bus_mode2 = 1'b0;
		sleep_req = 1'b1;
		step(20);
		check("asleep", 16'h0001, 16'(asleep));
		sleep_req = 1'b0;
		bus_in_a = 1'b0;
		bus_in_b = 1'b1;
		step(20);
		check("woken", 16'h0000, {15'h0, asleep | rx_bit});
		bus_in_a = 1'b1;
		bus_in_b = 1'b0;
		wait_frame(8'h00, port_in);
		check("bit_time", 16'(clp_pkg::BIT_CLKS_MAX), bit_time);
	endtask
	task automatic t_pin_reset();
		port_in[3:0] = 4'hb;
		reset_pin = 1'b1;
		step(4);
		check("oe_in_reset", 16'h0000, port_oe);
		reset_pin = 1'b0;
		step(8);
		check("node_id", 16'h000b, 16'(node_id_bits));
		check("internal", 16'h0000, 16'(ext_clock_mode));
		write(clp_pkg::ADDR_DRIVER_ENABLE, 16'h00f0, 16'h00f0);
		osc_select_pin = 1'b1;
		step(1);
		reset_pin = 1'b1;
		step(4);
		check("oe_kept", 16'h00f0, port_oe);
		osc_select_pin = 1'b0;
		step(4);
		check("oe_low_reset", 16'h0000, port_oe);
		osc_select_pin = 1'b1;
		step(8);
		check("external", 16'h0001, 16'(ext_clock_mode));
	endtask
	initial begin
		reset_n = 1'b0;
		reset_pin = 1'b0;
		osc_select_pin = 1'b0;
		bus_in_a = 1'b1;
		bus_in_b = 1'b0;
		bus_mode2 = 1'b0;
		tx_bit = 1'b1;
		sleep_req = 1'b0;
		comparator_result_bit = 3'h0;
		port_in = 16'h1234;
		step(4);
		reset_n = 1'b1;
		step(6);
		t_write_back();
		t_out_enable();
		t_read_only();
		t_convert();
		t_edge();
		t_bus();
		t_pin_reset();
		end_of_test();
	end
endmodule // clp_register_port_tb
bind clp_register_port clp_register_port_chk i_chk (.clk, .reset_n, .reset_pin, .osc_select_pin,
	.rx_frame_valid, .rx_frame_remote, .rx_byte1, .rx_byte2, .rx_byte3, .tx_req, .tx_addr,
	.tx_data, .tx_done, .bus_mode2, .tx_bit, .bus_out_low_drive_o, .bus_out_low_drive_oe,
	.bus_out_high_drive_oe, .port_in, .port_oe);
